// >>> hdl/oss_pkg.sv
// oss_pkg: shared constants and carriers for the output start-up sequencer.
// assumes a 200 MHz clock and a register port driven by a management-bus
// command decoder elsewhere in the device.
package oss_pkg;

  // register command codes
  localparam logic [7:0] OSS_REG_PG_ASSERT    = 8'h5E;
  localparam logic [7:0] OSS_REG_PG_DEASSERT  = 8'h5F;
  localparam logic [7:0] OSS_REG_TURN_ON_WAIT = 8'h60;
  localparam logic [7:0] OSS_REG_RAMP_UP      = 8'h61;
  localparam logic [7:0] OSS_REG_TIMEOUT_LIM  = 8'h62;
  localparam logic [7:0] OSS_REG_TIMEOUT_ACT  = 8'h63;

  // reset values (neutral defaults)
  localparam logic [15:0] OSS_RST_PG_ASSERT   = 16'h0000;
  localparam logic [15:0] OSS_RST_PG_DEASSERT = 16'h0000;
  localparam logic [15:0] OSS_RST_WAIT        = 16'h0000;
  localparam logic [15:0] OSS_RST_RAMP        = 16'h0000;
  localparam logic [15:0] OSS_RST_TIMEOUT     = 16'h0000;
  localparam logic [7:0]  OSS_RST_ACTION      = 8'h00;

  // action byte field positions
  localparam int OSS_RESP_HI  = 7;
  localparam int OSS_RESP_LO  = 6;
  localparam int OSS_RETRY_HI = 5;
  localparam int OSS_RETRY_LO = 3;
  localparam int OSS_DELAY_HI = 2;
  localparam int OSS_DELAY_LO = 0;

  localparam logic [1:0] OSS_RESP_IGNORE   = 2'h0;
  localparam logic [1:0] OSS_RESP_DELAYED  = 2'h1;
  localparam logic [1:0] OSS_RESP_DISABLE  = 2'h2;
  localparam logic [1:0] OSS_RESP_LATCHOFF = 2'h3;

  localparam logic [2:0] OSS_RETRY_NONE    = 3'h0;
  localparam logic [2:0] OSS_RETRY_FOREVER = 3'h7;

  // millisecond time base
  localparam int OSS_CLK_HZ     = 200_000_000;
  localparam int OSS_MS_PER_SEC = 1000;
  localparam int OSS_MS_CYCLES  = OSS_CLK_HZ / OSS_MS_PER_SEC;

  typedef enum logic [5:0] {
    OSS_ST_OFF     = 6'b000001,
    OSS_ST_WAIT    = 6'b000010,
    OSS_ST_RAMP    = 6'b000100,
    OSS_ST_ON      = 6'b001000,
    OSS_ST_HOLDOFF = 6'b010000,
    OSS_ST_LATCHED = 6'b100000
  } oss_state_t;

  typedef struct packed {
    logic [15:0] pg_assert_threshold;
    logic [15:0] pg_deassert_threshold;
    logic [15:0] turn_on_wait;
    logic [15:0] ramp_up_time;
    logic [15:0] startup_timeout_limit;
    logic [7:0]  startup_timeout_action;
  } oss_cfg_t;

  // register write/read port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } oss_reg_req_t;

endpackage

// >>> hdl/oss_output_startup_sequencer.sv
// oss_output_startup_sequencer: turn-on sequencing, power-good hysteresis
// and start-up timeout fault handling with retries.
// assumes vout_code, uv_reached and the control/clear inputs come from
// logic on clk; the delay unit (in ms) comes from a register held elsewhere.
// Function
// - assert output_ok_signal when vout reaches the assert threshold
// - deassert output_ok_signal when vout falls to the deassert threshold
// - after enable, wait turn_on_wait milliseconds before raising vout
// - then ramp vout over ramp_up_time milliseconds
// - timeout fault if undervoltage level not reached within limit
// - a zero limit means no timeout at all
// - response 00 ignores the fault and keeps operating
// - response 01 keeps operating for the delay, then applies retry
// - response 10 disables output at once, then applies retry
// - response 11 keeps output off until the fault is cleared
// - retry 000 makes no restart, output stays off until cleared
// - retry 001 gives one restart, then off until cleared
// - retry 010 gives two restarts, then off until cleared
// - restart attempts are spaced by 2 to the power delay code times delay unit
// - delay code decodes to 2 to the power code units
// - retry 011 to 110 give three to six restarts
// - retry 111 retries until commanded off or another fault
module oss_output_startup_sequencer #(
  parameter int MS_CYCLES = oss_pkg::OSS_MS_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire oss_pkg::oss_reg_req_t reg_req,
  output logic [15:0]               reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 output_enable_cmd,
  input  wire logic                 clear_faults,
  input  wire logic                 other_fault_shutdown,
  input  wire logic [15:0]          delay_unit_ms,
  input  wire logic [15:0]          vout_code,
  input  wire logic                 uv_reached,
  output logic                      output_ok_signal,
  output logic                      output_on,
  output logic                      ramp_active,
  output logic                      timeout_fault
);

  typedef struct packed {
    oss_pkg::oss_cfg_t   cfg;
    oss_pkg::oss_state_t st;
    logic [31:0]         tick_cnt;
    logic [15:0]         ms_cnt;
    logic [15:0]         to_cnt;
    logic [23:0]         unit_cnt;
    logic [2:0]          retries;
    logic                enable_prev;
    logic                fault;
    logic                pending;
    logic                pg;
    logic                on;
    logic                ramp;
    logic [15:0]         rdata;
    logic                rvalid;
  } oss_regs_t;

  oss_regs_t s_q;
  oss_regs_t s_d;

  logic        ms_tick;
  logic [1:0]  resp;
  logic [2:0]  retry_set;
  logic [2:0]  delay_code;
  logic [23:0] delay_ms;
  logic        en_rise;
  logic        en_fall;
  logic        to_expired;

  assign resp       = s_q.cfg.startup_timeout_action[oss_pkg::OSS_RESP_HI:
                                                     oss_pkg::OSS_RESP_LO];
  assign retry_set  = s_q.cfg.startup_timeout_action[oss_pkg::OSS_RETRY_HI:
                                                     oss_pkg::OSS_RETRY_LO];
  assign delay_code = s_q.cfg.startup_timeout_action[oss_pkg::OSS_DELAY_HI:
                                                     oss_pkg::OSS_DELAY_LO];
  assign delay_ms   = 24'(delay_unit_ms) << delay_code;
  assign ms_tick    = (s_q.tick_cnt == 32'(MS_CYCLES - 1));
  assign en_rise    = output_enable_cmd & ~s_q.enable_prev;
  assign en_fall    = ~output_enable_cmd & s_q.enable_prev;
  assign to_expired = (s_q.cfg.startup_timeout_limit != 16'h0000) &&
                      (s_q.to_cnt >= s_q.cfg.startup_timeout_limit);

  always_comb begin
    s_d = s_q;
    s_d.enable_prev = output_enable_cmd;
    s_d.rvalid = 1'b0;
    s_d.tick_cnt = ms_tick ? 32'h0 : s_q.tick_cnt + 32'h1;

    // register port: writes steer sequencing, reads return stored words
    if (reg_req.wr) begin
      unique case (reg_req.cmd)
        oss_pkg::OSS_REG_PG_ASSERT:
          s_d.cfg.pg_assert_threshold = reg_req.wdata;
        oss_pkg::OSS_REG_PG_DEASSERT:
          s_d.cfg.pg_deassert_threshold = reg_req.wdata;
        oss_pkg::OSS_REG_TURN_ON_WAIT:
          s_d.cfg.turn_on_wait = reg_req.wdata;
        oss_pkg::OSS_REG_RAMP_UP:
          s_d.cfg.ramp_up_time = reg_req.wdata;
        oss_pkg::OSS_REG_TIMEOUT_LIM:
          s_d.cfg.startup_timeout_limit = reg_req.wdata;
        oss_pkg::OSS_REG_TIMEOUT_ACT:
          s_d.cfg.startup_timeout_action = reg_req.wdata[7:0];
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      s_d.rvalid = 1'b1;
      unique case (reg_req.cmd)
        oss_pkg::OSS_REG_PG_ASSERT:    s_d.rdata = s_q.cfg.pg_assert_threshold;
        oss_pkg::OSS_REG_PG_DEASSERT:
          s_d.rdata = s_q.cfg.pg_deassert_threshold;
        oss_pkg::OSS_REG_TURN_ON_WAIT: s_d.rdata = s_q.cfg.turn_on_wait;
        oss_pkg::OSS_REG_RAMP_UP:      s_d.rdata = s_q.cfg.ramp_up_time;
        oss_pkg::OSS_REG_TIMEOUT_LIM:
          s_d.rdata = s_q.cfg.startup_timeout_limit;
        oss_pkg::OSS_REG_TIMEOUT_ACT:
          s_d.rdata = {8'h00, s_q.cfg.startup_timeout_action};
        default:                       s_d.rdata = 16'h0000;
      endcase
    end

    if (!s_q.on) begin
      s_d.pg = 1'b0;
    end else if (!s_q.pg && vout_code >= s_q.cfg.pg_assert_threshold) begin
      s_d.pg = 1'b1;
    end else if (s_q.pg && vout_code <= s_q.cfg.pg_deassert_threshold) begin
      s_d.pg = 1'b0;
    end

    if (ms_tick) begin
      s_d.ms_cnt = s_q.ms_cnt + 16'h1;
      s_d.unit_cnt = s_q.unit_cnt + 24'h1;
    end

    unique case (s_q.st)
      oss_pkg::OSS_ST_OFF: begin
        s_d.on = 1'b0;
        s_d.ramp = 1'b0;
        if (output_enable_cmd) begin
          s_d.st = oss_pkg::OSS_ST_WAIT;
          s_d.ms_cnt = 16'h0;
          s_d.retries = 3'h0;
          s_d.pending = 1'b0;
        end
      end
      oss_pkg::OSS_ST_WAIT: begin
        if (s_q.ms_cnt >= s_q.cfg.turn_on_wait) begin
          s_d.st = oss_pkg::OSS_ST_RAMP;
          s_d.ms_cnt = 16'h0;
          s_d.to_cnt = 16'h0;
          s_d.on = 1'b1;
          s_d.ramp = 1'b1;
        end
      end
      oss_pkg::OSS_ST_RAMP, oss_pkg::OSS_ST_ON: begin
        if (s_q.st == oss_pkg::OSS_ST_RAMP &&
            s_q.ms_cnt >= s_q.cfg.ramp_up_time) begin
          s_d.ramp = 1'b0;
          s_d.st = oss_pkg::OSS_ST_ON;
        end
        // timer until uv level
        // stops at a nonzero limit; entering ramp clears it so a retried start is timed afresh
        if (!uv_reached && ms_tick && !to_expired)
          s_d.to_cnt = s_q.to_cnt + 16'h1;
        if (uv_reached) begin
          s_d.pending = 1'b0;
        end else if (to_expired && !s_q.pending) begin
          s_d.fault = 1'b1;
          unique case (resp)
            oss_pkg::OSS_RESP_IGNORE: ;
            oss_pkg::OSS_RESP_DELAYED: begin
              s_d.pending = 1'b1;
              s_d.unit_cnt = 24'h0;
            end
            oss_pkg::OSS_RESP_DISABLE: begin
              s_d.st = oss_pkg::OSS_ST_HOLDOFF;
              s_d.unit_cnt = 24'h0;
              s_d.on = 1'b0;
              s_d.ramp = 1'b0;
            end
            default: begin
              s_d.st = oss_pkg::OSS_ST_LATCHED;
              s_d.on = 1'b0;
              s_d.ramp = 1'b0;
            end
          endcase
        end else if (s_q.pending && s_q.unit_cnt >= delay_ms) begin
          // fault persists: go to retry handling
          s_d.pending = 1'b0;
          s_d.st = oss_pkg::OSS_ST_HOLDOFF;
          s_d.unit_cnt = 24'h0;
        end
      end
      oss_pkg::OSS_ST_HOLDOFF: begin
        s_d.on = 1'b0;
        s_d.ramp = 1'b0;
        if (retry_set == oss_pkg::OSS_RETRY_NONE ||
            (retry_set != oss_pkg::OSS_RETRY_FOREVER &&
             s_q.retries >= retry_set)) begin
          s_d.st = oss_pkg::OSS_ST_LATCHED;
        end else if (s_q.unit_cnt >= delay_ms) begin
          if (retry_set != oss_pkg::OSS_RETRY_FOREVER)
            s_d.retries = s_q.retries + 3'h1;
          s_d.st = oss_pkg::OSS_ST_WAIT;
          s_d.ms_cnt = 16'h0;
        end
      end
      oss_pkg::OSS_ST_LATCHED: begin
        s_d.on = 1'b0;
        s_d.ramp = 1'b0;
        // clear by command or off-on cycle
        if (clear_faults || en_rise) begin
          s_d.fault = 1'b0;
          s_d.st = oss_pkg::OSS_ST_OFF;
        end
      end
      default: s_d.st = oss_pkg::OSS_ST_OFF;
    endcase

    // commanded off or other fault ends the start-up; the fault flag stays set, and a latch-off holds unless enable falls or clear
    if (!output_enable_cmd || other_fault_shutdown) begin
      s_d.st = (s_q.st == oss_pkg::OSS_ST_LATCHED && !en_fall && !clear_faults)
               ? oss_pkg::OSS_ST_LATCHED : oss_pkg::OSS_ST_OFF;
      s_d.on = 1'b0;
      s_d.ramp = 1'b0;
      s_d.pending = 1'b0;
      s_d.pg = 1'b0;
    end
    // clear-faults drops flag; a set that raises it on the same cycle wins
    if (clear_faults && s_d.fault == s_q.fault)
      s_d.fault = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.cfg <= '{oss_pkg::OSS_RST_PG_ASSERT, oss_pkg::OSS_RST_PG_DEASSERT,
                   oss_pkg::OSS_RST_WAIT, oss_pkg::OSS_RST_RAMP,
                   oss_pkg::OSS_RST_TIMEOUT, oss_pkg::OSS_RST_ACTION};
      s_q.st <= oss_pkg::OSS_ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign output_ok_signal = s_q.pg;
  assign output_on        = s_q.on;
  assign ramp_active      = s_q.ramp;
  assign timeout_fault    = s_q.fault;
  assign reg_rdata        = s_q.rdata;
  assign reg_rvalid       = s_q.rvalid;

endmodule

// >>> sim/oss_output_stage.sv
// oss_output_stage: far side model, the power stage and its sense path.
// assumes output_on from the sequencer; level is the target the bench sets.
module oss_output_stage (
  input  wire logic        clk,
  input  wire logic        on,
  input  wire logic [15:0] level,
  output logic [15:0]      vout_code,
  output logic             uv_reached
);
  timeunit 1ns;
  timeprecision 1ps;
  // slews one step a cycle so the sense path never jumps ahead of the ramp
  always_ff @(posedge clk) begin
    if (!on)
      vout_code <= 16'h0000;
    else if (vout_code < level)
      vout_code <= vout_code + 16'h0100;
    else if (vout_code > level)
      vout_code <= vout_code - 16'h0100;
  end
  assign uv_reached = vout_code >= 16'h3000;
endmodule

// >>> sim/oss_sequencer_checker.sv
// oss_sequencer_checker: port-level properties of the sequencer.
// assumes a single clk domain with synchronous active-low rstn.
module oss_sequencer_checker (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire oss_pkg::oss_reg_req_t reg_req,
  input wire logic                  reg_rvalid,
  input wire logic                  output_enable_cmd,
  input wire logic                  clear_faults,
  input wire logic                  other_fault_shutdown,
  input wire logic                  output_ok_signal,
  input wire logic                  output_on,
  input wire logic                  ramp_active,
  input wire logic                  timeout_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  chk_read_single: assert property (!reg_req.rd |=> !reg_rvalid)
    else $error("answer without read");
  chk_shutdown_off: assert property (
    other_fault_shutdown |=> !output_on) else $error("on after shutdown");
  chk_enable_off: assert property (
    !output_enable_cmd |=> !output_on) else $error("on while disabled");
  chk_ramp_on: assert property (
    ramp_active |-> output_on) else $error("ramp with output off");
  chk_pg_needs_on: assert property (
    !output_on [*2] |-> !output_ok_signal) else $error("good while off");
  chk_fault_sticky: assert property (
    timeout_fault && !clear_faults |=> timeout_fault)
    else $error("fault dropped without clear");
  chk_fault_cause: assert property (
    $rose(timeout_fault) |-> $past(output_enable_cmd))
    else $error("fault without start-up");
  chk_on_cause: assert property (
    $rose(output_on) |-> $past(output_enable_cmd)
      && !$past(other_fault_shutdown)) else $error("start not commanded");
endmodule
bind oss_output_startup_sequencer oss_sequencer_checker i_chk (
  .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
  .output_enable_cmd(output_enable_cmd), .clear_faults(clear_faults),
  .other_fault_shutdown(other_fault_shutdown),
  .output_ok_signal(output_ok_signal), .output_on(output_on),
  .ramp_active(ramp_active), .timeout_fault(timeout_fault));

// >>> sim/test_output_startup_sequencer.sv
// test_output_startup_sequencer: register, start-up and fault sequences.
// assumes MS_CYCLES shortened to 10 and a 1 ms fault delay unit.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_output_startup_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic clk, rstn, rvalid, en, clr, sd, uv, pg, on, ramp, flt;
  logic [15:0] rdata, lvl, vout, unit;
  oss_pkg::oss_reg_req_t req;
  int err_count, checked, starts, cycles, n;
  logic on_d;
  logic [7:0] acts [9] = '{8'h80, 8'h00, 8'h40, 8'hC0, 8'h88, 8'h90,
                           8'hB0, 8'h8F, 8'hB8};
  int exps [9] = '{1, 1, 1, 1, 2, 3, 7, 1, 0};
  logic [1:0] pgl [4] = '{2'h1, 2'h0, 2'h1, 2'h3};
  oss_output_startup_sequencer #(.MS_CYCLES(MS)) i_dut (
    .clk(clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .output_enable_cmd(en), .clear_faults(clr),
    .other_fault_shutdown(sd), .delay_unit_ms(unit),
    .vout_code(vout), .uv_reached(uv), .output_ok_signal(pg),
    .output_on(on), .ramp_active(ramp), .timeout_fault(flt));
  oss_output_stage i_stage (.clk(clk), .on(on), .level(lvl),
    .vout_code(vout), .uv_reached(uv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    on_d <= on;
    if (on && !on_d) starts++;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    req.wr = 1'b1; req.cmd = c; req.wdata = d;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    req.rd = 1'b1; req.cmd = c;
    cyc(1);
    req.rd = 1'b0;
    `CHK("read", {1'b1, e}, {rvalid, rdata})
    cyc(1);
  endtask
  initial begin
    rstn = 0; req = '0; en = 0; clr = 0; sd = 0; lvl = 16'h6000;
    unit = 16'h0001;
    cycles = 0; starts = 0; err_count = 0; checked = 0;
    cyc(10);
    rstn = 1;
    for (int i = 0; i < 6; i++) rd(8'(8'h5E + i), 16'h0000);
    wr(8'h70, 16'hFFFF);
    rd(8'h70, 16'h0000);
    for (int i = 0; i < 6; i++) wr(8'(8'h5E + i), 16'(16'hA5C3 ^ i));
    for (int i = 0; i < 6; i++)
      rd(8'(8'h5E + i), i == 5 ? 16'h00C6 : 16'(16'hA5C3 ^ i));
    wr(8'h5E, 16'h5000); wr(8'h5F, 16'h2000); wr(8'h60, 16'h0003);
    wr(8'h61, 16'h0004); wr(8'h62, 16'h0000); wr(8'h63, 16'h0000);
    en = 1; n = 0;
    while (on !== 1'b1 && n < 500) begin cyc(1); n++; end
    `CHK("wait", 1'b1, n >= 2 * MS && n <= 4 * MS + 2)
    `CHK("ramp on", 1'b1, ramp)
    n = 0;
    while (ramp !== 1'b0 && n < 500) begin cyc(1); n++; end
    `CHK("ramp", 1'b1, n >= 3 * MS && n <= 5 * MS + 2)
    cyc(100);
    `CHK("good", 1'b1, pg)
    foreach (pgl[i]) begin
      lvl = {pgl[i] == 2'h1 ? 4'h4 : pgl[i] == 2'h0 ? 4'h1 : 4'h6, 12'h000};
      cyc(70);
      `CHK("hyst", i != 1 && i != 2, pg)
    end
    lvl = 16'h1000;
    foreach (acts[i]) begin
      en = 0; clr = 1;
      cyc(1);
      clr = 0;
      cyc(1);
      `CHK("clear", 1'b0, flt)
      wr(8'h62, i == 0 ? 16'h0000 : 16'h0002);
      wr(8'h63, {8'h00, acts[i]});
      starts = 0; en = 1;
      cyc(900);
      if (exps[i] == 0) `CHK("forever", 1'b1, starts > 8)
      else begin
        `CHK("starts", exps[i], starts)
        `CHK("state", {i < 2, i != 0}, {on, flt})
      end
    end
    sd = 1;
    cyc(2);
    `CHK("shutdown", 1'b0, on)
    tally_and_finish();
  end
endmodule
